// file: hw/crgs_top.sv
// Reset generator, lock flag logic and register slave of the clock unit.
// Assumes clk_i is the controlled oscillator clock, Avalon-MM master on
// the bus side, and a reset pin resolved outside from its enable.
`timescale 1ns/1ps
`include "crgs_regs.svh"
module crgs_top (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Reset sources
    input  wire logic        reset_pin_i,
    input  wire logic        illegal_addr_i,
    input  wire logic        watchdog_timeout_i,
    input  wire logic        osc_clock_fail_i,
    // Lock detection and low power
    input  wire logic        lock_detect_i,
    input  wire logic        stop_mode_i,
    // Reset pin and processor
    output logic             reset_pin_o,
    output logic             reset_pin_oe_o,
    output logic             cpu_reset_o,
    output logic      [2:0]  vector_sel_o,
    output logic             lock_irq_o,
    // Clock and oscillator control
    output logic             bus_clk_en_o,
    output logic             osc_run_o,
    output logic             osc_amp_force_high_o,
    output logic      [7:0]  loop_tune_o
);

    // ------------------------------------------------------------------
    // Reset state of the whole module
    // ------------------------------------------------------------------
    localparam crgs_pkg::crgs_state_t RESET_STATE = '{
        seq:       crgs_pkg::SEQ_DRIVE,
        vec:       crgs_pkg::VEC_SYS,
        cpu_rst:   1'b1,
        pin_oe:    1'b1,
        wdog_pend: 1'b0,
        osc_pend:  1'b0,
        por_flag:  1'b1,
        ila_flag:  1'b0,
        lock_st:   1'b0,
        lock_flag: 1'b0,
        lock_ie:   1'b0,
        osc_en:    1'b0,
        tune:      `CRGS_TUNE_RESET,
        bus_div:   1'b0,
        ack:       1'b0,
        rdata:     8'h00
    };

    crgs_pkg::crgs_state_t s_reg;
    crgs_pkg::crgs_state_t s_next;

    crgs_cnt_if            cnt_bus ();

    logic [5:0]            word_idx;
    logic [7:0]            wdata;
    logic                  wr_en;
    logic                  wr_flag;
    logic                  wr_ctl0;
    logic                  wr_ctl1;
    logic                  wr_tune;
    logic                  osc_fail;
    logic                  int_event;
    logic                  lock_clr;
    logic                  lock_change;

    // ------------------------------------------------------------------
    // Phase counter
    // ------------------------------------------------------------------
    crgs_cycle_cnt #(
        .RESET_VAL (`CRGS_DRIVE_CYCLES - 10'h001)
    ) u_cycle_cnt (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .cnt_bus  (cnt_bus)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign word_idx = avs_address_i[7:2];
    assign wdata    = avs_writedata_i[7:0];
    assign wr_en    = avs_write_i & s_reg.ack & avs_byteenable_i[0];
    assign wr_flag  = wr_en & (word_idx == `CRGS_IDX_FLAG);
    assign wr_ctl0  = wr_en & (word_idx == `CRGS_IDX_CTL0);
    assign wr_ctl1  = wr_en & (word_idx == `CRGS_IDX_CTL1);
    assign wr_tune  = wr_en & (word_idx == `CRGS_IDX_TUNE);

    // ------------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------------
    assign osc_fail  = s_reg.osc_en & osc_clock_fail_i;                      // R08
    assign int_event = illegal_addr_i | watchdog_timeout_i | osc_fail;       // R01

    // ------------------------------------------------------------------
    // Lock status tracking
    // ------------------------------------------------------------------
    assign lock_clr    = stop_mode_i | wr_ctl0 | wr_tune;                    // R19
    assign lock_change = ~lock_clr & (lock_detect_i != s_reg.lock_st);       // R11

    // ------------------------------------------------------------------
    // Read value of a register index
    // ------------------------------------------------------------------
    function automatic logic [7:0] read_value(
        input crgs_pkg::crgs_state_t s,
        input logic [5:0]            idx
    );
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            `CRGS_IDX_FLAG: begin
                v[`CRGS_BIT_POR]    = s.por_flag;
                v[`CRGS_BIT_LOCKF]  = s.lock_flag;
                v[`CRGS_BIT_LOCK_ST] = s.lock_st;
                v[`CRGS_BIT_ILA]    = s.ila_flag;
            end
            `CRGS_IDX_CTL0: begin
                v[`CRGS_BIT_OSC_EN] = s.osc_en;
            end
            `CRGS_IDX_CTL1: begin
                v[`CRGS_BIT_LOCK_IE] = s.lock_ie;
            end
            `CRGS_IDX_TUNE: begin
                v = s.tune;
            end
            `CRGS_IDX_VECTOR: begin
                v = {5'h00, s.vec};
            end
            `CRGS_IDX_TEST_B: begin
                v = `CRGS_TEST_B_VALUE;                                       // R14
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next           = s_reg;
        cnt_bus.load     = 1'b0;
        cnt_bus.load_val = `CRGS_DRIVE_CYCLES;

        // Bus: one wait state, read data captured on the first cycle
        s_next.ack = (avs_read_i | avs_write_i) & ~s_reg.ack;
        if (avs_read_i & ~s_reg.ack) begin
            s_next.rdata = read_value(s_reg, word_idx);
        end

        // Control registers
        if (wr_ctl0) begin
            s_next.osc_en = wdata[`CRGS_BIT_OSC_EN];
        end
        if (wr_ctl1) begin
            s_next.lock_ie = wdata[`CRGS_BIT_LOCK_IE];
        end
        if (wr_tune) begin
            s_next.tune = wdata;
        end

        // Sticky flags: set wins over a clear in the same cycle
        if (wr_flag & wdata[`CRGS_BIT_POR]) begin
            s_next.por_flag = 1'b0;                                           // R17
        end
        if (wr_flag & wdata[`CRGS_BIT_ILA]) begin
            s_next.ila_flag = 1'b0;                                           // R18
        end
        if (illegal_addr_i) begin
            s_next.ila_flag = 1'b1;                                           // R18
        end
        if (wr_flag & wdata[`CRGS_BIT_LOCKF]) begin
            s_next.lock_flag = 1'b0;                                          // R12
        end
        if (lock_change) begin
            s_next.lock_flag = 1'b1;                                          // R11
        end

        // Lock status follows the loop unless forced clear
        if (lock_clr) begin
            s_next.lock_st = 1'b0;                                            // R19
        end else begin
            s_next.lock_st = lock_detect_i;
        end

        // Pending causes for vector selection
        if (watchdog_timeout_i) begin
            s_next.wdog_pend = 1'b1;                                          // R09
        end
        if (osc_fail) begin
            s_next.osc_pend = 1'b1;                                           // R08
        end

        // Reset sequencer
        case (s_reg.seq)
            crgs_pkg::SEQ_RUN: begin
                if (int_event | ~reset_pin_i) begin                           // R01
                    s_next.seq       = crgs_pkg::SEQ_DRIVE;
                    cnt_bus.load     = 1'b1;
                    cnt_bus.load_val = `CRGS_DRIVE_CYCLES;                    // R02
                end
            end
            crgs_pkg::SEQ_DRIVE: begin
                if (int_event) begin
                    cnt_bus.load     = 1'b1;
                    cnt_bus.load_val = `CRGS_DRIVE_CYCLES;
                end else if (cnt_bus.done) begin                              // R03
                    s_next.seq       = crgs_pkg::SEQ_WAIT;
                    cnt_bus.load     = 1'b1;
                    cnt_bus.load_val = `CRGS_WAIT_CYCLES;                     // R04
                end
            end
            crgs_pkg::SEQ_WAIT: begin
                if (int_event) begin
                    s_next.seq       = crgs_pkg::SEQ_DRIVE;
                    cnt_bus.load     = 1'b1;
                    cnt_bus.load_val = `CRGS_DRIVE_CYCLES;
                end else if (cnt_bus.done) begin                              // R04
                    s_next.wdog_pend = 1'b0;
                    s_next.osc_pend  = 1'b0;
                    if (!reset_pin_i) begin                                   // R05
                        s_next.vec = crgs_pkg::VEC_SYS;
                        s_next.seq = crgs_pkg::SEQ_HOLD;                      // R07
                    end else if (s_reg.osc_pend) begin
                        s_next.vec = crgs_pkg::VEC_OSC;                       // R20
                        s_next.seq = crgs_pkg::SEQ_RUN;
                    end else if (s_reg.wdog_pend) begin
                        s_next.vec = crgs_pkg::VEC_WDOG;                      // R09
                        s_next.seq = crgs_pkg::SEQ_RUN;
                    end else begin
                        s_next.vec = crgs_pkg::VEC_SYS;
                        s_next.seq = crgs_pkg::SEQ_RUN;
                    end
                end
            end
            crgs_pkg::SEQ_HOLD: begin
                if (int_event) begin
                    s_next.seq       = crgs_pkg::SEQ_DRIVE;
                    cnt_bus.load     = 1'b1;
                    cnt_bus.load_val = `CRGS_DRIVE_CYCLES;
                end else if (reset_pin_i) begin                               // R07
                    s_next.seq = crgs_pkg::SEQ_RUN;
                end
            end
            default: begin
                s_next.seq       = crgs_pkg::SEQ_DRIVE;
                cnt_bus.load     = 1'b1;
                cnt_bus.load_val = `CRGS_DRIVE_CYCLES;
            end
        endcase

        // Pin drive and processor reset follow the next state
        s_next.pin_oe  = (s_next.seq == crgs_pkg::SEQ_DRIVE);                 // R02
        s_next.cpu_rst = (s_next.seq != crgs_pkg::SEQ_RUN);                   // R06

        // Bus clock enable at half the core clock rate
        s_next.bus_div = ~s_reg.bus_div;                                      // R15
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg <= RESET_STATE;                                             // R03
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avs_readdata_o       = {24'h000000, s_reg.rdata};
    assign avs_waitrequest_o    = (avs_read_i | avs_write_i) & ~s_reg.ack;
    assign reset_pin_o          = 1'b0;
    assign reset_pin_oe_o       = s_reg.pin_oe;
    assign cpu_reset_o          = s_reg.cpu_rst;                              // R06
    assign vector_sel_o         = s_reg.vec;                                  // R20
    assign lock_irq_o           = s_reg.lock_flag & s_reg.lock_ie;            // R13
    assign bus_clk_en_o         = s_reg.bus_div;
    assign osc_run_o            = s_reg.osc_en;                               // R16
    assign osc_amp_force_high_o = ~s_reg.osc_en;                              // R16
    assign loop_tune_o          = s_reg.tune;

endmodule // crgs_top

// file: hw/crgs_regs.svh
// Constants of the clock reset generator sequencer: offsets, fields, counts.
// Assumes an 8-bit register set reached as word indices over a 32-bit bus.
//
// Summary of operation
// R01: Five reset sources start the reset sequence.
// R02: Drive reset pin low 516 cycles.
// R03: Entry asynchronous; exit sequencing needs running clock.
// R04: Wait 256 cycles after release, then sample.
// R05: Vector: low pin system, else osc, watchdog.
// R06: Processor reset held through whole sequence.
// R07: Processor reset held while pin held low.
// R08: Oscillator failure resets only when oscillator enabled.
// R09: Watchdog timeout resets and marks watchdog pending.
// R10: Board keeps pin rise within 256 cycles.
// R11: Lock status change sets lock flag.
// R12: Writing one clears lock flag.
// R13: Lock request only while lock enable set.
// R14: Factory test register readable, writes ignored.
// R15: Startup: core clock oscillator, bus half.
// R16: Oscillator off forces amplifier output high.
// R17: Power-on sets flag; write one clears.
// R18: Illegal access sets flag; write one clears.
// R19: Stop or control writes clear lock status silently.
// R20: Hold one-hot vector class after sequence.
`ifndef CRGS_REGS_SVH
`define CRGS_REGS_SVH

// ----------------------------------------------------------------------
// Sequence counts in oscillator clock cycles
// ----------------------------------------------------------------------
`define CRGS_CNT_W          10
`define CRGS_DRIVE_CYCLES   10'h204
`define CRGS_WAIT_CYCLES    10'h100
`define CRGS_SEQ_CYCLES     10'h300

// ----------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CRGS_IDX_FLAG       6'h30
`define CRGS_IDX_CTL0       6'h31
`define CRGS_IDX_CTL1       6'h32
`define CRGS_IDX_TUNE       6'h33
`define CRGS_IDX_VECTOR     6'h34
`define CRGS_IDX_TEST_B     6'h3B

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CRGS_BIT_POR        6
`define CRGS_BIT_LOCKF      4
`define CRGS_BIT_LOCK_ST    3
`define CRGS_BIT_ILA        2
`define CRGS_BIT_OSC_EN     7
`define CRGS_BIT_LOCK_IE    4
`define CRGS_TUNE_RESET     8'h00
`define CRGS_TEST_B_VALUE   8'h00

`endif

// file: hw/crgs_pkg.sv
// Types of the clock reset generator sequencer.
// Assumes the constants header is compiled alongside.
package crgs_pkg;

    // ------------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SEQ_RUN   = 4'h1,
        SEQ_DRIVE = 4'h2,
        SEQ_WAIT  = 4'h4,
        SEQ_HOLD  = 4'h8
    } crgs_seq_t;

    // ------------------------------------------------------------------
    // Reset vector classes, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        VEC_SYS  = 3'h1,
        VEC_OSC  = 3'h2,
        VEC_WDOG = 3'h4
    } crgs_vec_t;

    // ------------------------------------------------------------------
    // Whole state of the top module
    // ------------------------------------------------------------------
    typedef struct packed {
        crgs_seq_t   seq;
        crgs_vec_t   vec;
        logic        cpu_rst;
        logic        pin_oe;
        logic        wdog_pend;
        logic        osc_pend;
        logic        por_flag;
        logic        ila_flag;
        logic        lock_st;
        logic        lock_flag;
        logic        lock_ie;
        logic        osc_en;
        logic [7:0]  tune;
        logic        bus_div;
        logic        ack;
        logic [7:0]  rdata;
    } crgs_state_t;

endpackage

// file: hw/crgs_cnt_if.sv
// Link between the sequencer and its cycle counter.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`include "crgs_regs.svh"
interface crgs_cnt_if;
    logic                   load;
    logic [`CRGS_CNT_W-1:0] load_val;
    logic                   done;

    modport cnt (input load, input load_val, output done);
    modport ctl (output load, output load_val, input done);
endinterface

// file: hw/crgs_cycle_cnt.sv
// Down counter that times the drive and wait phases of the reset sequence.
// Assumes load carries the phase length in cycles, at least one.
`timescale 1ns/1ps
`include "crgs_regs.svh"
module crgs_cycle_cnt #(
    parameter logic [`CRGS_CNT_W-1:0] RESET_VAL = `CRGS_DRIVE_CYCLES - 10'h001
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    crgs_cnt_if.cnt   cnt_bus
);
    typedef struct packed {
        logic [`CRGS_CNT_W-1:0] count;
    } crgs_cnt_state_t;

    crgs_cnt_state_t s_reg;
    crgs_cnt_state_t s_next;

    // ------------------------------------------------------------------
    // Next count
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        if (cnt_bus.load) begin
            s_next.count = cnt_bus.load_val - 10'h001;
        end else if (s_reg.count != 10'h000) begin
            s_next.count = s_reg.count - 10'h001;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg.count <= RESET_VAL;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cnt_bus.done = (s_reg.count == 10'h000);

endmodule // crgs_cycle_cnt

// file: test/crgs_assertions.sv
// Assertion checker on the ports of the reset generator sequencer.
// Assumes it is bound into crgs_top and that all ports share clk_i.
`timescale 1ns/1ps
`include "crgs_regs.svh"
module crgs_assertions (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic        avs_waitrequest_o,
    input wire logic        reset_pin_i,
    input wire logic        illegal_addr_i,
    input wire logic        watchdog_timeout_i,
    input wire logic        osc_clock_fail_i,
    input wire logic        lock_detect_i,
    input wire logic        stop_mode_i,
    input wire logic        reset_pin_oe_o,
    input wire logic        cpu_reset_o,
    input wire logic [2:0]  vector_sel_o,
    input wire logic        lock_irq_o,
    input wire logic        bus_clk_en_o,
    input wire logic        osc_run_o,
    input wire logic        osc_amp_force_high_o
);
    // ------------------------------------------------------------
    // Phase counters
    // ------------------------------------------------------------
    logic [9:0] oe_cnt_reg;
    logic [9:0] wt_cnt_reg;
    wire        restart = illegal_addr_i | watchdog_timeout_i | (osc_run_o & osc_clock_fail_i);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            oe_cnt_reg <= 10'h000;
            wt_cnt_reg <= 10'h000;
        end else begin
            oe_cnt_reg <= (restart || !reset_pin_oe_o) ? 10'h000 : oe_cnt_reg + 10'h001;
            if (!cpu_reset_o || reset_pin_oe_o) begin
                wt_cnt_reg <= 10'h000;
            end else if (wt_cnt_reg != 10'h3FF) begin
                wt_cnt_reg <= wt_cnt_reg + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_drive_len: assert property ($fell(reset_pin_oe_o) |-> oe_cnt_reg == 10'h204)
        else $error("pin drive length wrong");
    a_wait_len: assert property ($fell(cpu_reset_o) |-> wt_cnt_reg >= 10'h100)
        else $error("release wait too short");
    a_pin_cover: assert property (reset_pin_oe_o |-> cpu_reset_o)
        else $error("processor out of reset while pin driven");
    a_event_entry: assert property (!cpu_reset_o && (restart || !reset_pin_i)
        |=> reset_pin_oe_o && cpu_reset_o) else $error("reset event ignored");
    a_osc_gated: assert property (!cpu_reset_o && !osc_run_o && !illegal_addr_i
        && !watchdog_timeout_i && reset_pin_i |=> !cpu_reset_o)
        else $error("reset without enabled source");
    a_pin_hold: assert property (cpu_reset_o && !reset_pin_oe_o && !reset_pin_i
        |=> cpu_reset_o) else $error("reset left while pin low");
    a_vec_hold: assert property (!cpu_reset_o && !$past(cpu_reset_o)
        |-> $onehot(vector_sel_o) && $stable(vector_sel_o)) else $error("vector unstable");
    a_w1c_lock: assert property (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
        && avs_address_i[7:2] == `CRGS_IDX_FLAG && avs_writedata_i[`CRGS_BIT_LOCKF]
        && $stable(lock_detect_i) && !stop_mode_i && !$past(stop_mode_i) |=> !lock_irq_o)
        else $error("lock flag not cleared");
    a_amp_forced: assert property (osc_amp_force_high_o != osc_run_o)
        else $error("amplifier force wrong");
    a_bus_half: assert property (1'b1 |=> bus_clk_en_o != $past(bus_clk_en_o))
        else $error("bus clock enable not toggling");
endmodule // crgs_assertions

bind crgs_top crgs_assertions crgs_assertions_i (.*);

// file: test/crgs_pin_model.sv
// Reset pin circuitry: pull-up, outside low driver and a slow rise.
// Assumes the design only ever pulls the pin low while enabled.
`timescale 1ns/1ps
module crgs_pin_model (
    input  wire logic       clk_i,
    input  wire logic       drive_low_i,
    input  wire logic       ext_low_i,
    input  wire logic [7:0] rise_dly_i,
    output logic            pin_o
);
    logic [7:0] rise_cnt_reg;

    // Pull-up recharges the pin within rise_dly_i cycles of release
    always_ff @(posedge clk_i) begin
        if (drive_low_i || ext_low_i) begin
            rise_cnt_reg <= 8'h00;
        end else if (rise_cnt_reg != rise_dly_i) begin
            rise_cnt_reg <= rise_cnt_reg + 8'h01;
        end
    end
    assign pin_o = !(drive_low_i || ext_low_i) && (rise_cnt_reg == rise_dly_i);
endmodule // crgs_pin_model

// file: test/tb.sv
// Self-checking bench of the reset generator sequencer.
// Assumes crgs_top, the pin model and the checker compile before it.
`timescale 1ns/1ps
`include "crgs_regs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, got, exp); end end
module tb;
    logic        clk_i              = 1'b0;
    logic        resetn_i           = 1'b0;
    logic [7:0]  avs_address_i      = 8'h00;
    logic        avs_read_i         = 1'b0;
    logic        avs_write_i        = 1'b0;
    logic [31:0] avs_writedata_i    = 32'h0;
    logic [3:0]  avs_byteenable_i   = 4'h0;
    logic        illegal_addr_i     = 1'b0;
    logic        watchdog_timeout_i = 1'b0;
    logic        osc_clock_fail_i   = 1'b0;
    logic        lock_detect_i      = 1'b0;
    logic        stop_mode_i        = 1'b0;
    logic        ext_low            = 1'b0;
    logic [7:0]  rise_dly           = 8'h00;
    logic [7:0]  tune;
    logic [31:0] avs_readdata_o, mon_exp;
    logic        avs_waitrequest_o, reset_pin_i, reset_pin_o, reset_pin_oe_o;
    logic        cpu_reset_o, lock_irq_o, bus_clk_en_o, osc_run_o, osc_amp_force_high_o;
    logic [2:0]  vector_sel_o;
    logic [7:0]  loop_tune_o;
    logic [31:0] exp_q[$];
    int          bad_count  = 0;
    int          num_checks = 0;

    crgs_top crgs_top_i (.*);
    crgs_pin_model crgs_pin_model_i (.clk_i(clk_i), .drive_low_i(reset_pin_oe_o & !reset_pin_o),
        .ext_low_i(ext_low), .rise_dly_i(rise_dly), .pin_o(reset_pin_i));

    always #25 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Tasks and read monitor
    // ------------------------------------------------------------
    task automatic bus(input logic rd, input logic [5:0] idx, input logic [7:0] wd,
                       input logic [7:0] ex);
        @(posedge clk_i);
        if (rd) exp_q.push_back({24'h0, ex});
        avs_address_i    <= {idx, 2'b00};
        avs_read_i       <= rd;
        avs_write_i      <= !rd;
        avs_writedata_i  <= {24'h0, wd};
        avs_byteenable_i <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    always @(posedge clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            mon_exp = exp_q.pop_front();
            `CHK(avs_readdata_o, mon_exp)
        end
    end

    task automatic seq_check();
        int oe_n, rst_n;
        oe_n = 0;
        rst_n = 0;
        do begin
            @(posedge clk_i);
            oe_n += (reset_pin_oe_o === 1'b1);
            rst_n += (cpu_reset_o === 1'b1);
        end while (cpu_reset_o !== 1'b0 || rst_n == 0);
        `CHK(oe_n, 516)
        `CHK(rst_n, 772)
    endtask

    task automatic tally_and_finish();
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hC263));
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        seq_check();
        bus(1, `CRGS_IDX_VECTOR, 8'h00, 8'h01);
        bus(1, `CRGS_IDX_FLAG, 8'h00, 8'h40);
        bus(0, `CRGS_IDX_FLAG, 8'h00, 8'h00);
        bus(1, `CRGS_IDX_FLAG, 8'h00, 8'h40);
        bus(0, `CRGS_IDX_FLAG, 8'h40, 8'h00);
        bus(1, `CRGS_IDX_FLAG, 8'h00, 8'h00);
        bus(0, `CRGS_IDX_TEST_B, 8'hFF, 8'h00);
        bus(1, `CRGS_IDX_TEST_B, 8'h00, `CRGS_TEST_B_VALUE);
        bus(1, 6'h05, 8'h00, 8'h00);
        tune = 8'($urandom);
        bus(0, `CRGS_IDX_TUNE, tune, 8'h00);
        bus(1, `CRGS_IDX_TUNE, 8'h00, tune);
        `CHK(loop_tune_o, tune)
        bus(0, `CRGS_IDX_CTL1, 8'h10, 8'h00);
        lock_detect_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK(lock_irq_o, 1'b1)
        bus(1, `CRGS_IDX_FLAG, 8'h00, 8'h18);
        bus(0, `CRGS_IDX_FLAG, 8'h10, 8'h00);
        bus(1, `CRGS_IDX_FLAG, 8'h00, 8'h08);
        bus(0, `CRGS_IDX_CTL1, 8'h00, 8'h00);
        lock_detect_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(lock_irq_o, 1'b0)
        bus(1, `CRGS_IDX_FLAG, 8'h00, 8'h10);
        bus(0, `CRGS_IDX_FLAG, 8'h10, 8'h00);
        lock_detect_i <= 1'b1;
        bus(0, `CRGS_IDX_FLAG, 8'h10, 8'h00);
        stop_mode_i <= 1'b1;
        bus(1, `CRGS_IDX_FLAG, 8'h00, 8'h00);
        stop_mode_i <= 1'b0;
        lock_detect_i <= 1'b0;
        rise_dly <= 8'hC8;
        watchdog_timeout_i <= 1'b1;
        @(posedge clk_i);
        watchdog_timeout_i <= 1'b0;
        seq_check();
        bus(1, `CRGS_IDX_VECTOR, 8'h00, 8'h04);
        osc_clock_fail_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        `CHK(cpu_reset_o, 1'b0)
        osc_clock_fail_i <= 1'b0;
        bus(0, `CRGS_IDX_CTL0, 8'h80, 8'h00);
        @(posedge clk_i);
        `CHK({osc_run_o, osc_amp_force_high_o}, 2'b10)
        osc_clock_fail_i <= 1'b1;
        watchdog_timeout_i <= 1'b1;
        @(posedge clk_i);
        osc_clock_fail_i <= 1'b0;
        watchdog_timeout_i <= 1'b0;
        seq_check();
        bus(1, `CRGS_IDX_VECTOR, 8'h00, 8'h02);
        bus(0, `CRGS_IDX_CTL0, 8'h00, 8'h00);
        @(posedge clk_i);
        `CHK({osc_run_o, osc_amp_force_high_o}, 2'b01)
        illegal_addr_i <= 1'b1;
        @(posedge clk_i);
        illegal_addr_i <= 1'b0;
        seq_check();
        bus(1, `CRGS_IDX_FLAG, 8'h00, 8'h04);
        bus(0, `CRGS_IDX_FLAG, 8'h04, 8'h00);
        bus(1, `CRGS_IDX_FLAG, 8'h00, 8'h00);
        bus(1, `CRGS_IDX_VECTOR, 8'h00, 8'h01);
        rise_dly <= 8'h00;
        ext_low <= 1'b1;
        watchdog_timeout_i <= 1'b1;
        @(posedge clk_i);
        watchdog_timeout_i <= 1'b0;
        repeat (1000) @(posedge clk_i);
        `CHK(cpu_reset_o, 1'b1)
        ext_low <= 1'b0;
        for (int i = 0; i < 20 && cpu_reset_o !== 1'b0; i++) @(posedge clk_i);
        `CHK(cpu_reset_o, 1'b0)
        bus(1, `CRGS_IDX_VECTOR, 8'h00, 8'h01);
        tally_and_finish();
    end
endmodule // tb
